//--- drt_pkg.sv
// Shared constants and types for the dual reload timer block
`default_nettype none
package drt_pkg;

	// Clock rates: system clock, oscillator input and the derived counting clocks
	localparam int CLK_HZ   = 250_000_000;
	localparam int OSC_HZ   = 10_000_000;
	localparam int INSTR_HZ = 2_000_000;
	localparam int FAST_HZ  = 20_000_000;

	// Cycles of clk_i per counting tick, rounded down to whole cycles
	localparam logic [6:0] INSTR_DIV_CNT = 7'(CLK_HZ / INSTR_HZ);
	localparam logic [6:0] FAST_DIV_CNT  = 7'(CLK_HZ / FAST_HZ);

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_COUNT = 8'h04;
	localparam logic [7:0] OFF_RLD_A = 8'h08;
	localparam logic [7:0] OFF_RLD_B = 8'h0C;
	localparam logic [7:0] OFF_SPEED = 8'h10;

	// Values after reset
	localparam logic [7:0]  CTRL_RST  = 8'h00;
	localparam logic [7:0]  SPEED_RST = 8'h00;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [15:0] RLD_RST   = 16'h0000;

	// Field positions in the speed-select register
	localparam int HS_SECOND_BIT = 0;
	localparam int HS_THIRD_BIT  = 1;
	localparam int HS_WIDTH      = 2;

	// Mode codes in ctrl bits 3..1
	localparam logic [2:0] MODE_PWM_TOGGLE = 3'h5;
	localparam logic [2:0] MODE_PWM_PLAIN  = 3'h4;
	localparam logic [2:0] MODE_EVT_RISE   = 3'h0;
	localparam logic [2:0] MODE_EVT_FALL   = 3'h1;

	// Control register layout, bit 7 first
	typedef struct packed {
		logic       pending_flag_a;
		logic       irq_enable_a;
		logic       pending_flag_b;
		logic       irq_enable_b;
		logic [2:0] mode_sel;
		logic       run_or_underflow_bit;
	} drt_ctrl_t;

	// Data phase of the bus slave
	typedef enum logic [2:0] {
		BUS_IDLE  = 3'b001,
		BUS_WRITE = 3'b010,
		BUS_READ  = 3'b100
	} drt_bus_t;

endpackage
`default_nettype wire

//--- drt_edge_sync.sv
// Two-stage pin synchroniser on the counting clock with edge pulses
`timescale 1ns/10ps
`default_nettype none
module drt_edge_sync (
	input  wire logic clk_i,
	input  wire logic reset_i,
	input  wire logic tick_i,
	input  wire logic pin_i,
	output logic      rise_o,
	output logic      fall_o
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	// Stages advance only on the counting tick
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else if (tick_i) begin
			meta_reg <= pin_i;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	// Pulses only on tick cycles, one per edge
	assign rise_o = tick_i & sync_reg & ~last_reg;
	assign fall_o = tick_i & ~sync_reg & last_reg;

endmodule
`default_nettype wire

//--- drt_timer.sv
// Dual reload timer: counter, reload/capture registers, modes and AHB-Lite slave
//
// Contract
// - 16-bit counter, two reload/capture registers
// - io pin bidirectional, input pin input only
// - Three mode bits select three modes
// - Second, third instances may use fast clock
// - Instruction clock 2 MHz, fast 20 MHz; fast tick is every 12 clk_i cycles, about 20.8 MHz
// - Speed select bits 1/0, reset 00
// - PWM reloads A first, then alternate
// - PWM toggle option inverts io pin
// - PWM flags A/B set, software clears
// - PWM interrupts gated by enables A/B
// - Event count on synced chosen io edge
// - Event underflow sets flag A, irq
// - Input pin rise sets flag B, irq
// - Event mode drives no PWM output
// - Capture copies counter on pin triggers
// - Capture edge polarity per pin selectable
// - Captures readable while counter runs
// - Capture triggers set flags, enables gate
// - Capture underflow sets run bit, enable A
// - Run bit starts/stops PWM and event
// - Mode encoding as listed table
//
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module drt_timer #(
	parameter logic       FAST_CAPABLE = 1'b1,
	parameter int         FAST_SEL_BIT = drt_pkg::HS_SECOND_BIT,
	parameter int         CNT_W        = 16,
	parameter logic [6:0] INSTR_DIV    = drt_pkg::INSTR_DIV_CNT,
	parameter logic [6:0] FAST_DIV     = drt_pkg::FAST_DIV_CNT
) (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic        timer_io_pin_i,
	output logic             timer_io_pin_o,
	output logic             timer_io_pin_oe_o,
	input  wire logic        timer_input_pin_i,
	output logic             irq_a_o,
	output logic             irq_b_o
);
	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
		reg_hit = (addr == off);
	endfunction

	drt_pkg::drt_bus_t  bus_state_reg;
	drt_pkg::drt_bus_t  bus_state_next;
	logic [7:0]         addr_reg;
	logic [31:0]        hrdata_reg;
	drt_pkg::drt_ctrl_t ctrl_reg;
	drt_pkg::drt_ctrl_t ctrl_next;
	logic [7:0]         speed_reg;
	logic [CNT_W-1:0]   count_reg;
	logic [CNT_W-1:0]   count_next;
	logic [CNT_W-1:0]   rld_a_reg;
	logic [CNT_W-1:0]   rld_a_next;
	logic [CNT_W-1:0]   rld_b_reg;
	logic [CNT_W-1:0]   rld_b_next;
	logic               sel_b_reg;
	logic               pin_out_reg;
	logic [6:0]         div_instr_reg;
	logic [6:0]         div_fast_reg;

	// Bus decode
	wire        addr_phase = hsel_i & htrans_i[1] & hready_i;
	wire        wr_phase   = (bus_state_reg == drt_pkg::BUS_WRITE);
	wire        we_ctrl    = wr_phase & reg_hit(addr_reg, drt_pkg::OFF_CTRL);
	wire        we_count   = wr_phase & reg_hit(addr_reg, drt_pkg::OFF_COUNT);
	wire        we_rld_a   = wr_phase & reg_hit(addr_reg, drt_pkg::OFF_RLD_A);
	wire        we_rld_b   = wr_phase & reg_hit(addr_reg, drt_pkg::OFF_RLD_B);
	wire        we_speed   = wr_phase & reg_hit(addr_reg, drt_pkg::OFF_SPEED);
	wire [7:0]  rd_addr    = haddr_i[7:0];
	wire [31:0] rd_word    =
		reg_hit(rd_addr, drt_pkg::OFF_CTRL)  ? {24'h000000, ctrl_reg} :
		reg_hit(rd_addr, drt_pkg::OFF_COUNT) ? {{(32-CNT_W){1'b0}}, count_reg} :
		reg_hit(rd_addr, drt_pkg::OFF_RLD_A) ? {{(32-CNT_W){1'b0}}, rld_a_reg} :
		reg_hit(rd_addr, drt_pkg::OFF_RLD_B) ? {{(32-CNT_W){1'b0}}, rld_b_reg} :
		reg_hit(rd_addr, drt_pkg::OFF_SPEED) ? {24'h000000, speed_reg} :
		32'h00000000;

	// Zero wait states, always OKAY
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign hrdata_o    = hrdata_reg;

	always_comb begin
		bus_state_next = drt_pkg::BUS_IDLE;
		if (addr_phase) begin
			bus_state_next = hwrite_i ? drt_pkg::BUS_WRITE : drt_pkg::BUS_READ;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			bus_state_reg <= drt_pkg::BUS_IDLE;
			addr_reg      <= 8'h00;
			hrdata_reg    <= 32'h00000000;
		end else begin
			bus_state_reg <= bus_state_next;
			if (addr_phase) begin
				addr_reg <= rd_addr;
			end
			if (addr_phase & ~hwrite_i) begin
				hrdata_reg <= rd_word; // Sampled without halting the count
			end
		end
	end

	// Counting clock dividers
	wire tick_instr = (div_instr_reg == INSTR_DIV - 7'h01);
	wire tick_fast  = (div_fast_reg == FAST_DIV - 7'h01);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			div_instr_reg <= 7'h00;
			div_fast_reg  <= 7'h00;
		end else begin
			div_instr_reg <= tick_instr ? 7'h00 : div_instr_reg + 7'h01;
			div_fast_reg  <= tick_fast ? 7'h00 : div_fast_reg + 7'h01;
		end
	end

	// Timer one has no fast option
	wire fast_sel = FAST_CAPABLE & speed_reg[FAST_SEL_BIT];
	wire tick     = fast_sel ? tick_fast : tick_instr;

	// Mode decode
	wire [2:0] mode       = ctrl_reg.mode_sel;
	wire       run        = ctrl_reg.run_or_underflow_bit;
	wire       is_pwm     = mode[2] & ~mode[1];
	wire       is_evt     = ~mode[2] & ~mode[1];
	wire       is_cap     = mode[1];
	wire       pwm_toggle = is_pwm & mode[0];
	wire       evt_fall   = mode[0];
	wire       cap_a_fall = mode[0];
	wire       cap_b_fall = mode[2];

	// Pin edges, synchronised on the selected clock
	logic a_rise;
	logic a_fall;
	logic b_rise;
	logic b_fall;

	drt_edge_sync u_sync_a (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.tick_i  (tick),
		.pin_i   (timer_io_pin_i),
		.rise_o  (a_rise),
		.fall_o  (a_fall)
	);

	// Input-only pin, never driven
	drt_edge_sync u_sync_b (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.tick_i  (tick),
		.pin_i   (timer_input_pin_i),
		.rise_o  (b_rise),
		.fall_o  (b_fall)
	);

	// Count sources per mode
	wire evt_edge  = evt_fall ? a_fall : a_rise;
	wire cnt_dec   = (is_pwm & run & tick) | (is_evt & run & evt_edge) | (is_cap & tick);
	wire at_zero   = (count_reg == '0);
	wire uf        = cnt_dec & at_zero;
	wire pwm_uf    = uf & is_pwm;
	wire cap_a_evt = is_cap & (cap_a_fall ? a_fall : a_rise);
	wire cap_b_evt = is_cap & (cap_b_fall ? b_fall : b_rise);
	wire cap_uf    = uf & is_cap;
	wire [CNT_W-1:0] pwm_reload = sel_b_reg ? rld_b_reg : rld_a_reg;

	// Flag sources; a hardware set beats a software clear
	wire set_a = (pwm_uf & ~sel_b_reg) | (uf & is_evt) | cap_a_evt;
	wire set_b = (pwm_uf & sel_b_reg) | (is_evt & b_rise) | cap_b_evt;

	always_comb begin
		ctrl_next = ctrl_reg;
		if (we_ctrl) begin
			ctrl_next = hwdata_i[7:0]; // Always writable, any mode
		end
		if (set_a) begin
			ctrl_next.pending_flag_a = 1'b1;
		end
		if (set_b) begin
			ctrl_next.pending_flag_b = 1'b1;
		end
		if (cap_uf) begin
			ctrl_next.run_or_underflow_bit = 1'b1;
		end
	end

	always_comb begin
		count_next = count_reg;
		if (we_count) begin
			count_next = hwdata_i[CNT_W-1:0];
		end else if (cnt_dec) begin
			if (at_zero & is_pwm) begin
				count_next = pwm_reload;
			end else begin
				count_next = count_reg - 1'b1; // Wraps to all ones
			end
		end
	end

	// Captures win over a same-cycle software write
	always_comb begin
		rld_a_next = we_rld_a ? hwdata_i[CNT_W-1:0] : rld_a_reg;
		rld_b_next = we_rld_b ? hwdata_i[CNT_W-1:0] : rld_b_reg;
		if (cap_a_evt) begin
			rld_a_next = count_reg;
		end
		if (cap_b_evt) begin
			rld_b_next = count_reg;
		end
	end

	// Register state
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ctrl_reg  <= drt_pkg::CTRL_RST;
			speed_reg <= drt_pkg::SPEED_RST;
			count_reg <= CNT_W'(drt_pkg::COUNT_RST);
			rld_a_reg <= CNT_W'(drt_pkg::RLD_RST);
			rld_b_reg <= CNT_W'(drt_pkg::RLD_RST);
		end else begin
			ctrl_reg  <= ctrl_next;
			count_reg <= count_next;
			rld_a_reg <= rld_a_next;
			rld_b_reg <= rld_b_next;
			if (we_speed) begin
				speed_reg <= {6'h00, hwdata_i[drt_pkg::HS_WIDTH-1:0]};
			end
		end
	end

	// Reload selector restarts at A whenever PWM is stopped
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sel_b_reg   <= 1'b0;
			pin_out_reg <= 1'b0;
		end else begin
			if (~(is_pwm & run)) begin
				sel_b_reg <= 1'b0;
			end else if (pwm_uf) begin
				sel_b_reg <= ~sel_b_reg;
			end
			if (pwm_uf & pwm_toggle) begin
				pin_out_reg <= ~pin_out_reg;
			end
		end
	end

	// Pin driven only in PWM mode
	assign timer_io_pin_o    = pin_out_reg;
	assign timer_io_pin_oe_o = is_pwm;

	// Interrupt requests; in capture mode channel A also covers underflow
	assign irq_a_o = ctrl_reg.irq_enable_a & (ctrl_reg.pending_flag_a | (is_cap & run));
	assign irq_b_o = ctrl_reg.irq_enable_b & ctrl_reg.pending_flag_b;

	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	property p_pwm_reload;
		pwm_uf && !we_count |=> count_reg == $past(pwm_reload);
	endproperty
	a_pwm_reload: assert property (p_pwm_reload) else $error("PWM reload value wrong");

	property p_pwm_first_a;
		$rose(is_pwm && run) |-> !sel_b_reg;
	endproperty
	a_pwm_first_a: assert property (p_pwm_first_a) else $error("First PWM reload not from A");

	property p_pwm_toggle;
		pwm_uf && pwm_toggle |=> timer_io_pin_o != $past(timer_io_pin_o);
	endproperty
	a_pwm_toggle: assert property (p_pwm_toggle) else $error("PWM pin did not toggle");

	property p_flag_a_set;
		set_a |=> ctrl_reg.pending_flag_a;
	endproperty
	a_flag_a_set: assert property (p_flag_a_set) else $error("Flag A lost");

	property p_irq_b;
		ctrl_reg.pending_flag_b && ctrl_reg.irq_enable_b |-> irq_b_o ##1 (irq_b_o || !ctrl_reg.pending_flag_b
			|| !ctrl_reg.irq_enable_b);
	endproperty
	a_irq_b: assert property (p_irq_b) else $error("Channel B request wrong");

	property p_irq_a_off;
		!ctrl_reg.irq_enable_a |-> !irq_a_o;
	endproperty
	a_irq_a_off: assert property (p_irq_a_off) else $error("Disabled A request raised");

	property p_evt_no_drive;
		is_evt |-> !timer_io_pin_oe_o;
	endproperty
	a_evt_no_drive: assert property (p_evt_no_drive) else $error("Pin driven in event mode");

	property p_capture_a;
		cap_a_evt |=> rld_a_reg == $past(count_reg) && ctrl_reg.pending_flag_a;
	endproperty
	a_capture_a: assert property (p_capture_a) else $error("Capture A wrong");

	property p_capture_b;
		cap_b_evt |=> rld_b_reg == $past(count_reg) && ctrl_reg.pending_flag_b;
	endproperty
	a_capture_b: assert property (p_capture_b) else $error("Capture B wrong");

	property p_cap_wrap;
		cap_uf && !we_count |=> count_reg == '1 && ctrl_reg.run_or_underflow_bit;
	endproperty
	a_cap_wrap: assert property (p_cap_wrap) else $error("Capture underflow wrong");

	property p_tick_spacing;
		tick_fast |=> !tick_fast [*8];
	endproperty
	a_tick_spacing: assert property (p_tick_spacing) else $error("Fast tick too frequent");

	property p_slow_only;
		!FAST_CAPABLE || !speed_reg[FAST_SEL_BIT] |-> tick == tick_instr;
	endproperty
	a_slow_only: assert property (p_slow_only) else $error("Timer one on fast clock");

	property p_stopped;
		(is_pwm || is_evt) && !run && !we_count |=> count_reg == $past(count_reg);
	endproperty
	a_stopped: assert property (p_stopped) else $error("Stopped timer counted");

	c_pwm_uf: cover property (pwm_uf ##[1:1000] pwm_uf);
	c_cap_a: cover property (cap_a_evt);
	c_evt_b: cover property (is_evt && b_rise);
	c_cap_uf: cover property (cap_uf);

endmodule
`default_nettype wire

//--- drt_pin_src.sv
// Pin-side model: pulse sources on both timer pins
`timescale 1ns/10ps
`default_nettype none
module drt_pin_src (
	input  wire logic io_lvl_i,
	input  wire logic in_lvl_i,
	input  wire logic dev_o_i,
	input  wire logic dev_oe_i,
	output logic      io_pin_o,
	output logic      in_pin_o
);
	// Source yields the io pin while the device drives it
	assign io_pin_o = dev_oe_i ? dev_o_i : io_lvl_i;
	// Input-only pin, never driven by the device
	assign in_pin_o = in_lvl_i;
endmodule
`default_nettype wire

//--- test_dual_reload_timer_block.sv
// Testbench for the dual reload timer block
`timescale 1ns/10ps
`default_nettype none
module test_dual_reload_timer_block;
	logic        clk_i      = 1'b0;
	logic        reset_i    = 1'b1;
	logic        hsel       = 1'b0;
	logic [31:0] haddr      = 32'h00000000;
	logic [1:0]  htrans     = 2'h0;
	logic        hwrite     = 1'b0;
	logic [31:0] hwdata     = 32'h00000000;
	logic        io_lvl     = 1'b0;
	logic        in_lvl     = 1'b0;
	logic [31:0] hrdata, rdv, cnt;
	logic        hrdy, hresp, io_pin, in_pin, pin_o, pin_oe, irq_a, irq_b;
	logic [31:0] seed       = 32'd17833;
	int          n_mismatch = 0;
	int          num_checks = 0;
	logic        seq[$]     = '{1'b0, 1'b1, 1'b0, 1'b1};
	int          cap[4]     = '{2, 6, 3, 7};
	logic        tog;
	logic [2:0]  m;

	// Short divisors keep the run brief; fast divisor kept at 9 or more
	localparam int FDIV = 9;
	drt_timer #(.FAST_CAPABLE(1'b1), .INSTR_DIV(7'h0A), .FAST_DIV(7'(FDIV))) i_drt_timer (
		.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
		.hreadyout_o(hrdy), .hresp_o(hresp), .timer_io_pin_i(io_pin), .timer_io_pin_o(pin_o),
		.timer_io_pin_oe_o(pin_oe), .timer_input_pin_i(in_pin), .irq_a_o(irq_a), .irq_b_o(irq_b));
	drt_pin_src i_drt_pin_src (.io_lvl_i(io_lvl), .in_lvl_i(in_lvl), .dev_o_i(pin_o), .dev_oe_i(pin_oe),
		.io_pin_o(io_pin), .in_pin_o(in_pin));

	initial begin
		forever #2 clk_i = ~clk_i;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic results();
		if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask

	// Single word transfer; read data lands in rdv
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge clk_i);
		while (hrdy !== 1'b1) @(posedge clk_i);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk_i);
		while (hrdy !== 1'b1) @(posedge clk_i);
		rdv = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h00000000);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
		rd(a);
		chk(nm, e, rdv);
	endtask

	// Pin levels held two or more ticks so the synchroniser cannot miss them
	task automatic lv(input logic a, input logic b);
		@(posedge clk_i);
		io_lvl <= a;
		in_lvl <= b;
		repeat (40 + xs() % 20) @(posedge clk_i);
	endtask

	initial begin
		repeat (20) @(posedge clk_i);
		reset_i <= 1'b0;
		for (int a = 0; a <= 32; a += 4) rc(8'(a), 32'h00000000, "reset_val");
		wr(8'h20, 32'hFFFFFFFF);
		rc(8'h20, 32'h00000000, "unmapped");
		wr(drt_pkg::OFF_RLD_A, 32'h00000003);
		wr(drt_pkg::OFF_RLD_B, 32'h00000005);
		tog = 1'b0;
		for (int p = 5; p >= 4; p--) begin
			wr(drt_pkg::OFF_CTRL, 32'h00000000);
			wr(drt_pkg::OFF_COUNT, 32'h00000002);
			wr(drt_pkg::OFF_CTRL, {24'h000000, 4'h4, 3'(p), 1'b1});
			foreach (seq[i]) begin
				rd(drt_pkg::OFF_CTRL);
				while (rdv[7] !== 1'b1 && rdv[5] !== 1'b1) rd(drt_pkg::OFF_CTRL);
				tog ^= (p == 5);
				chk("pend", {!seq[i], seq[i]}, {rdv[7], rdv[5]});
				chk("irq_a", !seq[i], irq_a);
				chk("irq_b", 32'h0, irq_b);
				chk("pin", tog, pin_o);
				chk("oe", 32'h1, pin_oe);
				wr(drt_pkg::OFF_CTRL, {24'h000000, 4'h4, 3'(p), 1'b1});
			end
		end
		for (int e = 0; e < 2; e++) begin
			wr(drt_pkg::OFF_CTRL, 32'h00000000);
			wr(drt_pkg::OFF_COUNT, 32'h00000002);
			wr(drt_pkg::OFF_CTRL, {24'h000000, 3'h2, e[0], 2'h0, e[0], 1'b1});
			cnt = 32'h2;
			repeat (3) begin
				lv(1'b1, 1'b0);
				lv(1'b0, 1'b0);
				cnt = (cnt - 1) & 32'h0000FFFF;
				rc(drt_pkg::OFF_COUNT, cnt, "count");
			end
			rd(drt_pkg::OFF_CTRL);
			chk("flag_a", 32'h1, rdv[7]);
			chk("irq_a", 32'h1, irq_a);
			chk("oe", 32'h0, pin_oe);
			lv(1'b0, 1'b1);
			lv(1'b0, 1'b0);
			rd(drt_pkg::OFF_CTRL);
			chk("flag_b", 32'h1, rdv[5]);
			chk("irq_b", e, irq_b);
		end
		wr(drt_pkg::OFF_CTRL, 32'h00000040);
		lv(1'b1, 1'b0);
		lv(1'b0, 1'b0);
		rc(drt_pkg::OFF_COUNT, 32'h0000FFFF, "stopped");
		wr(drt_pkg::OFF_SPEED, 32'hFFFFFFFF);
		rc(drt_pkg::OFF_SPEED, 32'h00000003, "speed_sel");
		wr(drt_pkg::OFF_CTRL, 32'h00000044);
		wr(drt_pkg::OFF_COUNT, 32'h00000003);
		repeat (100) @(posedge clk_i);
		rc(drt_pkg::OFF_CTRL, 32'h00000045, "underflow");
		chk("irq_a", 32'h1, irq_a);
		foreach (cap[i]) begin
			m = 3'(cap[i]);
			wr(drt_pkg::OFF_CTRL, {24'h000000, 4'h5, m, 1'b0});
			lv(1'b1, 1'b1);
			rd(drt_pkg::OFF_CTRL);
			chk("cap_rise", {!m[0], !m[2]}, {rdv[7], rdv[5]});
			chk("irq_ab", {!m[0], !m[2]}, {irq_a, irq_b});
			lv(1'b0, 1'b0);
			rd(drt_pkg::OFF_CTRL);
			chk("cap_fall", 32'h3, {rdv[7], rdv[5]});
		end
		cnt = xs();
		wr(drt_pkg::OFF_COUNT, {16'h0000, 1'b1, cnt[14:0]});
		rd(drt_pkg::OFF_COUNT);
		cnt = rdv;
		repeat (87) @(posedge clk_i);
		rd(drt_pkg::OFF_COUNT);
		// Address phases 90 cycles apart, so exactly 90 / FDIV fast ticks
		chk("count_running", (cnt - 32'(90 / FDIV)) & 32'h0000FFFF, rdv);
		results();
	end

	// Whole run is about 2000 cycles; cut off at 25000
	initial begin
		#100000;
		n_mismatch++;
		results();
	end
endmodule
`default_nettype wire
